// File: design/converter_mode_status.sv
// Converter mode status register with update inhibit and calibration mode hold
`timescale 1ns/1ns
`default_nettype none
module converter_mode_status (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register access from the serial management interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_addr_valid,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  output logic [7:0] reg_rdata,
  // Supply pin level
  input wire logic aux_supply_pin,
  // Converter mode requests from the converters
  input wire logic [1:0] output_a_mode_req,
  input wire logic output_b_mode_req,
  // Calibration in progress per output
  input wire logic calib_a_active,
  input wire logic calib_b_active,
  // Modes applied to the converters
  output logic [1:0] output_a_converter_mode,
  output logic output_b_converter_mode,
  // Illegal write to the reserved bits seen
  output logic reserved_write_err
);
  // ==========================================================
  // Synchronisers
  logic [5:0] sync_vec;
  logic aux_s;
  logic [1:0] a_req_s;
  logic b_req_s;
  logic cal_a_s;
  logic cal_b_s;

  level_sync #(.WIDTH(6)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({aux_supply_pin, output_a_mode_req, output_b_mode_req,
               calib_a_active, calib_b_active}),
    .sync_out(sync_vec)
  );

  // Split synchronised levels
  assign aux_s = sync_vec[5];
  assign a_req_s = sync_vec[4:3];
  assign b_req_s = sync_vec[2];
  assign cal_a_s = sync_vec[1];
  assign cal_b_s = sync_vec[0];

  // ==========================================================
  // State
  typedef enum logic [1:0] {POR_WAIT, POR_SETTLE, POR_SAMPLE, RUN} por_state_t;
  por_state_t por_q, por_d;
  logic single_cell_q, single_cell_d;
  logic [1:0] a_mode_q, a_mode_d;
  logic b_mode_q, b_mode_d;
  logic [1:0] a_view_q, a_view_d;
  logic b_view_q, b_view_d;
  logic [7:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic addressed;

  // Address decode used by the read path, the inhibit and the reserved-write check
  function automatic logic hits(input logic [7:0] addr, input logic valid);
    hits = valid && (addr == mode_status_pkg::CONVERTER_MODE_STATUS_OFFSET);
  endfunction : hits

  assign addressed = hits(reg_addr, reg_addr_valid);

  // Next-state computation
  always_comb begin
    por_d = por_q;
    single_cell_d = single_cell_q;
    a_mode_d = a_mode_q;
    b_mode_d = b_mode_q;
    a_view_d = a_view_q;
    b_view_d = b_view_q;
    err_d = 1'b0;
    rdata_d = 8'h00;
    case (por_q)
      // Both synchroniser stages must fill before the pin level is trusted
      POR_WAIT: por_d = POR_SETTLE;
      POR_SETTLE: por_d = POR_SAMPLE;
      POR_SAMPLE: begin
        single_cell_d = aux_s;
        por_d = RUN;
      end
      RUN: por_d = RUN;
      default: por_d = POR_WAIT;
    endcase
    if (!cal_a_s) begin
      a_mode_d = a_req_s;
    end
    if (!cal_b_s) begin
      b_mode_d = b_req_s;
    end
    if (!addressed) begin
      a_view_d = a_mode_q;
      b_view_d = b_mode_q;
    end
    if (addressed) begin
      rdata_d[mode_status_pkg::SINGLE_CELL_BIT] = single_cell_q;
      rdata_d[mode_status_pkg::OUTPUT_B_MODE_BIT] = b_view_q;
      rdata_d[mode_status_pkg::OUTPUT_A_MODE_MSB:mode_status_pkg::OUTPUT_A_MODE_LSB] = a_view_q;
    end
    if (addressed && reg_write) begin
      err_d = (reg_wdata[mode_status_pkg::RESERVED_MSB:mode_status_pkg::RESERVED_LSB] != 4'h0);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_q <= POR_WAIT;
      single_cell_q <= mode_status_pkg::SINGLE_CELL_RESET;
      a_mode_q <= mode_status_pkg::OUTPUT_A_RESET;
      b_mode_q <= mode_status_pkg::OUTPUT_B_RESET;
      a_view_q <= mode_status_pkg::OUTPUT_A_RESET;
      b_view_q <= mode_status_pkg::OUTPUT_B_RESET;
      rdata_q <= mode_status_pkg::CONVERTER_MODE_STATUS_RESET;
      err_q <= 1'b0;
    end else begin
      por_q <= por_d;
      single_cell_q <= single_cell_d;
      a_mode_q <= a_mode_d;
      b_mode_q <= b_mode_d;
      a_view_q <= a_view_d;
      b_view_q <= b_view_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // Outputs from flops
  assign reg_rdata = rdata_q;
  assign output_a_converter_mode = a_mode_q;
  assign output_b_converter_mode = b_mode_q;
  assign reserved_write_err = err_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_addr_held;
    addressed [*2];
  endsequence

  chk_view_frozen_a: assert property (s_addr_held |=> $stable(a_view_q))
    else $error("output A view changed while addressed");
  chk_view_frozen_b: assert property (s_addr_held |=> $stable(b_view_q))
    else $error("output B view changed while addressed");
  chk_cal_hold_a: assert property (cal_a_s |=> a_mode_q == $past(a_mode_q))
    else $error("output A mode moved during calibration");
  chk_cal_hold_b: assert property (cal_b_s |=> b_mode_q == $past(b_mode_q))
    else $error("output B mode moved during calibration");
  chk_single_fixed: assert property (por_q == RUN |=> $stable(single_cell_q))
    else $error("single cell indicator changed after power-on");
  chk_read_b_bit: assert property (addressed |=> reg_rdata[2] == $past(b_view_q))
    else $error("bit 2 does not show output B mode");
  chk_read_a_field: assert property (addressed |=> reg_rdata[1:0] == $past(a_view_q))
    else $error("bits 1:0 do not show output A mode");
  chk_reserved_zero: assert property (reg_rdata[7:4] == 4'h0)
    else $error("reserved bits read nonzero");
  chk_single_read: assert property (addressed |=> reg_rdata[3] == $past(single_cell_q))
    else $error("bit 3 does not show the single cell indicator");
  chk_idle_read_zero: assert property (!addressed |=> reg_rdata == 8'h00)
    else $error("read data not zero while unaddressed");

  // Mode path: requests pass straight through unless a calibration holds them
  chk_a_follow: assert property (!cal_a_s |=> a_mode_q == $past(a_req_s))
    else $error("output A mode does not follow its request");
  chk_b_follow: assert property (!cal_b_s |=> b_mode_q == $past(b_req_s))
    else $error("output B mode does not follow its request");

  // Readback view keeps tracking the applied modes whenever the host is away
  chk_view_track_a: assert property (!addressed |=> a_view_q == $past(a_mode_q))
    else $error("output A view stalled while unaddressed");
  chk_view_track_b: assert property (!addressed |=> b_view_q == $past(b_mode_q))
    else $error("output B view stalled while unaddressed");

  // Power-on capture of the aux pin: settle, sample once, then run for good
  sequence s_por_settle;
    por_q == POR_SETTLE;
  endsequence

  sequence s_por_finish;
    (por_q == POR_SAMPLE) ##1 (por_q == RUN);
  endsequence

  chk_por_steps: assert property (s_por_settle |=> s_por_finish)
    else $error("power-on capture skipped a step");
  chk_por_run_stays: assert property (por_q == RUN |=> por_q == RUN)
    else $error("power-on capture left the run state");
  chk_single_take: assert property (por_q == POR_SAMPLE |=> single_cell_q == $past(aux_s))
    else $error("single cell indicator missed the aux pin level");

  // Reserved-bit write flag: one pulse per offending write, quiet otherwise
  sequence s_bad_write;
    addressed && reg_write &&
      (reg_wdata[mode_status_pkg::RESERVED_MSB:mode_status_pkg::RESERVED_LSB] != 4'h0);
  endsequence

  chk_err_pulse: assert property (s_bad_write |=> reserved_write_err)
    else $error("nonzero reserved write not flagged");
  chk_err_quiet: assert property (!(addressed && reg_write) |=> !reserved_write_err)
    else $error("reserved write flag raised without a write");
endmodule : converter_mode_status
`default_nettype wire

// File: design/mode_status_pkg.sv
// Package: offsets, field layout, reset values and mode encodings of the converter mode status
package mode_status_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] CONVERTER_MODE_STATUS_OFFSET = 8'h12;
  localparam logic [7:0] CONVERTER_MODE_STATUS_RESET = 8'h00;
  // ==========================================================
  // Field positions
  localparam int SINGLE_CELL_BIT = 3;
  localparam int OUTPUT_B_MODE_BIT = 2;
  localparam int OUTPUT_A_MODE_LSB = 0;
  localparam int OUTPUT_A_MODE_MSB = 1;
  localparam int RESERVED_LSB = 4;
  localparam int RESERVED_MSB = 7;
  // ==========================================================
  // Mode encodings
  localparam logic OUTPUT_B_BUCK = 1'b0;
  localparam logic OUTPUT_B_LINEAR = 1'b1;
  localparam logic [1:0] OUTPUT_A_BUCK = 2'h0;
  localparam logic [1:0] OUTPUT_A_AUTO = 2'h1;
  localparam logic [1:0] OUTPUT_A_BOOST = 2'h2;
  localparam logic [1:0] OUTPUT_A_LINEAR_PAR = 2'h3;
  localparam logic [1:0] OUTPUT_A_RESET = 2'h0;
  localparam logic OUTPUT_B_RESET = 1'b0;
  localparam logic SINGLE_CELL_RESET = 1'b0;
endpackage : mode_status_pkg

// File: design/level_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;
endmodule : level_sync
`default_nettype wire

// File: testbench/host_model.sv
// Host firmware model driving the register access port
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock
  input wire logic core_clk,
  // Register access
  output logic [7:0] reg_addr,
  output logic reg_addr_valid,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  input wire logic [7:0] reg_rdata,
  input wire logic reserved_write_err
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_addr_valid = 1'b0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
  end
  logic [2:0] last_modes = 3'h0;
  logic [7:0] recompute_count = 8'h00;
  // One charge-per-pulse recompute per change of the mode fields seen on unload
  task automatic note_modes(input logic [7:0] d);
    if (d[2:0] !== last_modes) begin
      recompute_count = recompute_count + 8'h01;
      last_modes = d[2:0];
    end
  endtask : note_modes
  // Address for n+1 cycles; d0 is the first view, d1 the last
  // address while reading
  task automatic access(input logic [7:0] a, input logic [7:0] wd, input logic wr,
                        input int n, output logic [7:0] d0, output logic [7:0] d1,
                        output logic err);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= wd;
    reg_write <= wr;
    reg_addr_valid <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(negedge core_clk);
    d0 = reg_rdata;
    err = reserved_write_err;
    repeat (n) @(posedge core_clk);
    reg_addr_valid <= 1'b0;
    reg_addr <= ~a; // Released bus shows no stale value
    reg_wdata <= ~wd;
    @(negedge core_clk);
    d1 = reg_rdata;
  endtask : access
endmodule : host_model
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the converter mode status register
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk, rst_n, aux_supply_pin, output_b_mode_req, calib_a_active, calib_b_active;
  logic reg_write, reg_addr_valid, reserved_write_err, output_b_converter_mode, err;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d0, d1;
  logic [1:0] output_a_mode_req, output_a_converter_mode;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // Clock at 25 MHz
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  converter_mode_status DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_addr_valid(reg_addr_valid), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_rdata(reg_rdata), .aux_supply_pin(aux_supply_pin),
    .output_a_mode_req(output_a_mode_req), .output_b_mode_req(output_b_mode_req),
    .calib_a_active(calib_a_active), .calib_b_active(calib_b_active),
    .output_a_converter_mode(output_a_converter_mode),
    .output_b_converter_mode(output_b_converter_mode), .reserved_write_err(reserved_write_err));
  host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_addr_valid(reg_addr_valid),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
    .reserved_write_err(reserved_write_err));
  // Compare one byte
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // Cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      report_and_stop();
    end
  end
  // Plain one-shot read
  task automatic rd(input logic [7:0] a);
    host.access(a, 8'h00, 1'b0, 1, d0, d1, err);
    if (a == 8'h12) begin
      host.note_modes(d0);
    end
  endtask : rd
  // Apply converter side inputs and let them settle
  task automatic drive(input logic [1:0] a, input logic b, input logic c, input logic ax);
    @(posedge core_clk);
    output_a_mode_req <= a;
    output_b_mode_req <= b;
    calib_a_active <= c;
    calib_b_active <= c;
    aux_supply_pin <= ax;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk); // Outputs settled before anyone looks
  endtask : drive
  // Main sequence
  initial begin
    rst_n = 1'b0;
    aux_supply_pin = 1'b1;
    output_a_mode_req = 2'h0;
    output_b_mode_req = 1'b0;
    calib_a_active = 1'b0;
    calib_b_active = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd(8'h12);
    check(d0, 8'h08);
    drive(2'h0, 1'b0, 1'b0, 1'b0);
    rd(8'h12);
    check(d0, 8'h08);
    for (int i = 0; i < 8; i++) begin
      drive(i[1:0], i[2], 1'b0, 1'b0);
      rd(8'h12);
      check(d0, {4'h0, 1'b1, i[2], i[1:0]});
      check({5'h00, output_b_converter_mode, output_a_converter_mode}, {5'h00, i[2], i[1:0]});
    end
    rd(8'h13);
    check(d0, 8'h00);
    host.access(8'h12, 8'hF0, 1'b1, 1, d0, d1, err);
    check({7'h00, err}, 8'h01);
    host.access(8'h12, 8'h05, 1'b1, 1, d0, d1, err);
    check({7'h00, err}, 8'h00);
    check(d0, 8'h0F);
    fork
      host.access(8'h12, 8'h00, 1'b0, 8, d0, d1, err);
      begin
        repeat (2) @(posedge core_clk);
        output_a_mode_req <= mode_status_pkg::OUTPUT_A_AUTO;
      end
    join
    check(d1, 8'h0F);
    rd(8'h12);
    check(d0, 8'h0D);
    drive(2'h1, 1'b1, 1'b1, 1'b0);
    drive(2'h2, 1'b0, 1'b1, 1'b0);
    check({5'h00, output_b_converter_mode, output_a_converter_mode}, 8'h05);
    drive(2'h2, 1'b0, 1'b0, 1'b0);
    check({5'h00, output_b_converter_mode, output_a_converter_mode}, 8'h02);
    // Mid-run reset clears the modes and recaptures the pin, now low
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(negedge core_clk);
    check({5'h00, output_b_converter_mode, output_a_converter_mode}, 8'h00);
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(8'h12);
    check(d0, 8'h02);
    check(host.recompute_count, 8'h09);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
